// File: rtl/fmfl_params.svh
`ifndef FMFL_PARAMS_SVH
`define FMFL_PARAMS_SVH

// Serial word layout: 20 data bits above a 4-bit control address.
`define FMFL_WORD_W 24
`define FMFL_ADDR_LSB 0
`define FMFL_ADDR_W 4

// Control addresses of the words this block listens to.
`define FMFL_CODE_FN_LO 4'h1
`define FMFL_CODE_FD_LO 4'h3
`define FMFL_CODE_FD_HI 4'h5
`define FMFL_CODE_FN_HI 4'hb
`define FMFL_CODE_CTRL 4'hd

// Field positions (least significant bit of each field).
`define FMFL_LO_LSB 4
`define FMFL_HI_LSB 14
`define FMFL_FDHI_LSB 4
`define FMFL_ACCESS_BIT 16
`define FMFL_TOC_LSB 4
`define FMFL_CPF_LSB 18
`define FMFL_CSR_LSB 22

// Field widths.
`define FMFL_LO_W 12
`define FMFL_HI_W 10
`define FMFL_FRAC_W 22
`define FMFL_TOC_W 14
`define FMFL_CPF_W 4
`define FMFL_CSR_W 2

// Reset values and time-out thresholds.
`define FMFL_RST_LO 12'h000
`define FMFL_RST_HI 10'h000
`define FMFL_RST_TOC 14'h0000
`define FMFL_RST_CPF 4'h0
`define FMFL_RST_CSR 2'h0
`define FMFL_TOC_MANUAL 14'h0001
`define FMFL_TOC_DRV_LO 14'h0002
`define FMFL_TOC_DRV_HI 14'h0003
`define FMFL_TOC_TIMED_MIN 14'h0004

`endif

// File: rtl/fmfl_pkg.sv
`default_nettype none

package fmfl_pkg;

    // Fastlock sequencing states.
    typedef enum logic [1:0] {
        FMFL_IDLE = 2'b00,
        FMFL_TIMED = 2'b01,
        FMFL_MANUAL = 2'b10
    } fmfl_fl_state_t;

    typedef logic [23:0] fmfl_word_t;
    typedef logic [21:0] fmfl_frac_t;

endpackage

`default_nettype wire

// File: rtl/fmfl_serial_rx.sv
`timescale 1ns/10ps
`default_nettype none

// Three-wire write receiver: shifts data on rising clock, latches on rising enable.
module fmfl_serial_rx (
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Serial pins.
    input wire logic ser_data,
    input wire logic ser_clk,
    input wire logic ser_le,
    // Latched word.
    output fmfl_pkg::fmfl_word_t word_q,
    output logic word_valid_q
);
    import fmfl_pkg::*;

    logic [2:0] meta_q, meta_d, sync_q, sync_d, prev_q, prev_d;
    fmfl_word_t shift_q, shift_d, word_d;
    logic word_valid_d;

    // Two synchroniser flops per pin, then a history flop; edges compare the second and third stages.
    always_comb begin
        meta_d = {ser_data, ser_clk, ser_le};
        sync_d = meta_q;
        prev_d = sync_q;
        shift_d = shift_q;
        word_d = word_q;
        word_valid_d = 1'b0;
        if (sync_q[1] && !prev_q[1]) begin
            shift_d = {shift_q[22:0], sync_q[2]};
        end
        if (sync_q[0] && !prev_q[0]) begin
            word_d = shift_q;
            word_valid_d = 1'b1;
        end
    end

    // Registers freeze while the enable is low.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
            prev_q <= 3'h0;
            shift_q <= 24'h000000;
            word_q <= 24'h000000;
            word_valid_q <= 1'b0;
        end else if (ce) begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
            shift_q <= shift_d;
            word_q <= word_d;
            word_valid_q <= word_valid_d;
        end
    end

endmodule // fmfl_serial_rx

`default_nettype wire

// File: rtl/fmfl_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "fmfl_params.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Width bit low: 12-bit values, upper ignored.
// - Width bit high: numerator is 22 bits.
// - Width bit high: denominator is 22 bits.
// - Time-out 0, 2, 3: fastlock off, pin general output (released at 0, low at 2, high at 3).
// - Time-out 1: manual fastlock, pin low.
// - Time-out 4..16383: timed fastlock, pin indicates.
// - Timed fastlock lasts twice time-out comparison cycles.
// - Cycle-slip field divides sample rate 1,2,4,16.
// - Fastlock pump current is code plus one.
module fmfl_timer (
    // Clock, reset and enable.
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic CE,
    // Three-wire serial write port.
    input wire logic SER_DATA,
    input wire logic SER_CLK,
    input wire logic SER_LE,
    // Phase-detector comparison event, from the comparator clock domain.
    input wire logic PD_COMPARE,
    // Fastlock pin.
    output logic FL_PIN_O,
    output logic FL_PIN_OE,
    // Modulator and charge pump controls.
    output fmfl_pkg::fmfl_frac_t FRAC_NUM,
    output fmfl_pkg::fmfl_frac_t FRAC_DEN,
    output logic FASTLOCK_ACTIVE,
    output logic [4:0] FL_PUMP_MULT,
    output logic [2:0] CSR_SHIFT
);
    import fmfl_pkg::*;

    fmfl_word_t word;
    logic word_valid;
    logic [`FMFL_ADDR_W-1:0] code;
    logic [`FMFL_LO_W-1:0] fn_lo_q, fn_lo_d, fd_lo_q, fd_lo_d;
    logic [`FMFL_HI_W-1:0] fn_hi_q, fn_hi_d, fd_hi_q, fd_hi_d;
    logic access_q, access_d;
    logic [`FMFL_TOC_W-1:0] toc_q, toc_d;
    logic [`FMFL_CPF_W-1:0] cpf_q, cpf_d;
    logic [`FMFL_CSR_W-1:0] csr_q, csr_d;
    fmfl_fl_state_t st_q, st_d;
    logic [`FMFL_TOC_W:0] cnt_q, cnt_d;
    logic cmp_meta_q, cmp_sync_q, cmp_prev_q, cmp_event;
    fmfl_frac_t num_d, den_d;
    logic pin_o_d, pin_oe_d, active_d;
    logic [4:0] mult_d;
    logic [2:0] shift_d;

    ////////////////////////////////////////////////////////////////////////////
    // Serial receiver; pins are synchronised inside it.
    fmfl_serial_rx u_rx (
        .clk(MCLK),
        .rst_n(RESETN),
        .ce(CE),
        .ser_data(SER_DATA),
        .ser_clk(SER_CLK),
        .ser_le(SER_LE),
        .word_q(word),
        .word_valid_q(word_valid)
    );

    assign code = word[`FMFL_ADDR_LSB +: `FMFL_ADDR_W];

    ////////////////////////////////////////////////////////////////////////////
    // Register file: a latched word updates only the fields of its address.
    always_comb begin
        fn_lo_d = fn_lo_q;
        fn_hi_d = fn_hi_q;
        fd_lo_d = fd_lo_q;
        fd_hi_d = fd_hi_q;
        access_d = access_q;
        toc_d = toc_q;
        cpf_d = cpf_q;
        csr_d = csr_q;
        if (word_valid && code == `FMFL_CODE_FN_LO) begin
            fn_lo_d = word[`FMFL_LO_LSB +: `FMFL_LO_W];
        end else if (word_valid && code == `FMFL_CODE_FN_HI) begin
            fn_hi_d = word[`FMFL_HI_LSB +: `FMFL_HI_W];
        end else if (word_valid && code == `FMFL_CODE_FD_LO) begin
            fd_lo_d = word[`FMFL_LO_LSB +: `FMFL_LO_W];
            access_d = word[`FMFL_ACCESS_BIT];
        end else if (word_valid && code == `FMFL_CODE_FD_HI) begin
            fd_hi_d = word[`FMFL_FDHI_LSB +: `FMFL_HI_W];
        end else if (word_valid && code == `FMFL_CODE_CTRL) begin
            toc_d = word[`FMFL_TOC_LSB +: `FMFL_TOC_W];
            cpf_d = word[`FMFL_CPF_LSB +: `FMFL_CPF_W];
            csr_d = word[`FMFL_CSR_LSB +: `FMFL_CSR_W];
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            fn_lo_q <= `FMFL_RST_LO;
            fn_hi_q <= `FMFL_RST_HI;
            fd_lo_q <= `FMFL_RST_LO;
            fd_hi_q <= `FMFL_RST_HI;
            access_q <= 1'b0;
            toc_q <= `FMFL_RST_TOC;
            cpf_q <= `FMFL_RST_CPF;
            csr_q <= `FMFL_RST_CSR;
        end else if (CE) begin
            fn_lo_q <= fn_lo_d;
            fn_hi_q <= fn_hi_d;
            fd_lo_q <= fd_lo_d;
            fd_hi_q <= fd_hi_d;
            access_q <= access_d;
            toc_q <= toc_d;
            cpf_q <= cpf_d;
            csr_q <= csr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Comparison events come from another clock; two flops, then an edge.
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
            cmp_prev_q <= 1'b0;
        end else if (CE) begin
            cmp_meta_q <= PD_COMPARE;
            cmp_sync_q <= cmp_meta_q;
            cmp_prev_q <= cmp_sync_q;
        end
    end

    assign cmp_event = cmp_sync_q && !cmp_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // Fastlock sequencer. The low numerator word or a control word (re)starts it, so a
    // single write both retunes and opens fastlock; the host must keep the
    // comparison clock under the system clock rate or events merge.
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        if (word_valid && (code == `FMFL_CODE_FN_LO || code == `FMFL_CODE_CTRL)) begin
            cnt_d = '0;
            if (toc_d == `FMFL_TOC_MANUAL) begin
                st_d = FMFL_MANUAL;
            end else if (toc_d >= `FMFL_TOC_TIMED_MIN) begin
                st_d = FMFL_TIMED;
            end else begin
                st_d = FMFL_IDLE;
            end
        end else begin
            case (st_q)
                FMFL_TIMED: begin
                    if (cmp_event) begin
                        // Stay for twice the time-out in comparison events.
                        if (cnt_q + 15'h0001 >= {toc_q, 1'b0}) begin
                            st_d = FMFL_IDLE;
                            cnt_d = '0;
                        end else begin
                            cnt_d = cnt_q + 15'h0001;
                        end
                    end
                end
                default: begin
                    st_d = st_q;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            st_q <= FMFL_IDLE;
            cnt_q <= '0;
        end else if (CE) begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output decode. Upper parts count only in 22-bit mode.
    always_comb begin
        num_d = access_q ? {fn_hi_q, fn_lo_q} : {10'h000, fn_lo_q};
        den_d = access_q ? {fd_hi_q, fd_lo_q} : {10'h000, fd_lo_q};
        active_d = (st_q != FMFL_IDLE);
        mult_d = {1'b0, cpf_q} + 5'h01;
        case (csr_q)
            2'h1: shift_d = 3'h1;
            2'h2: shift_d = 3'h2;
            2'h3: shift_d = 3'h4;
            default: shift_d = 3'h0;
        endcase
        // Pin: general output below 4, fastlock indication from 4 up.
        pin_oe_d = 1'b1;
        pin_o_d = 1'b0;
        if (toc_q >= `FMFL_TOC_TIMED_MIN) begin
            pin_o_d = (st_q == FMFL_TIMED);
        end else if (toc_q == `FMFL_TOC_DRV_HI) begin
            pin_o_d = 1'b1;
        end else if (toc_q == `FMFL_RST_TOC) begin
            pin_oe_d = 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            FRAC_NUM <= '0;
            FRAC_DEN <= '0;
            FASTLOCK_ACTIVE <= 1'b0;
            FL_PUMP_MULT <= 5'h01;
            CSR_SHIFT <= 3'h0;
            FL_PIN_O <= 1'b0;
            FL_PIN_OE <= 1'b0;
        end else if (CE) begin
            FRAC_NUM <= num_d;
            FRAC_DEN <= den_d;
            FASTLOCK_ACTIVE <= active_d;
            FL_PUMP_MULT <= mult_d;
            CSR_SHIFT <= shift_d;
            FL_PIN_O <= pin_o_d;
            FL_PIN_OE <= pin_oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    num_width_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        CE && !access_q |=> FRAC_NUM[21:12] == 10'h000 && FRAC_DEN[21:12] == 10'h000)
        else $error("upper fraction bits used in 12-bit mode");
    num_wide_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        CE && access_q |=> FRAC_NUM == {$past(fn_hi_q), $past(fn_lo_q)})
        else $error("22-bit numerator wrong");
    den_wide_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        CE && access_q |=> FRAC_DEN == {$past(fd_hi_q), $past(fd_lo_q)})
        else $error("22-bit denominator wrong");
    pin_gpio_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        CE && toc_q == 14'h0000 ##1 CE && toc_q == 14'h0000 |=> !FL_PIN_OE && !FASTLOCK_ACTIVE)
        else $error("pin driven while time-out is zero");
    manual_mode_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        CE && word_valid && code == 4'hd && word[17:4] == 14'h0001 |=> CE [*2] ##0 1'b1
        |=> FASTLOCK_ACTIVE && FL_PIN_OE && !FL_PIN_O)
        else $error("manual fastlock not entered");
    timed_pin_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        CE && toc_q >= 14'h0004 |=> FL_PIN_OE && FL_PIN_O == $past(st_q == FMFL_TIMED))
        else $error("fastlock pin does not follow timer");
    timed_end_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        CE && st_q == FMFL_TIMED && cmp_event && !word_valid && cnt_q + 15'h0001 == {toc_q, 1'b0}
        |=> st_q == FMFL_IDLE ##1 CE [*1] |=> !FASTLOCK_ACTIVE)
        else $error("timed fastlock did not end on count");
    timed_hold_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        CE && st_q == FMFL_TIMED && !word_valid && cnt_q + 15'h0001 < {toc_q, 1'b0} |=> st_q == FMFL_TIMED)
        else $error("timed fastlock ended early");
    csr_map_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        CE && csr_q == 2'h3 |=> CSR_SHIFT == 3'h4)
        else $error("cycle-slip factor wrong");
    pump_map_a: assert property (@(posedge MCLK) disable iff (!RESETN)
        CE |=> FL_PUMP_MULT == {1'b0, $past(cpf_q)} + 5'h01)
        else $error("fastlock pump multiple wrong");

    timed_run_c: cover property (@(posedge MCLK) disable iff (!RESETN)
        st_q == FMFL_TIMED ##1 st_q == FMFL_IDLE);
    manual_c: cover property (@(posedge MCLK) disable iff (!RESETN) st_q == FMFL_MANUAL);
    wide_c: cover property (@(posedge MCLK) disable iff (!RESETN) access_q && FRAC_NUM[21:12] != 10'h000);

endmodule // fmfl_timer

`default_nettype wire

// File: dv/fmfl_host.sv
`timescale 1ns/10ps
`default_nettype none

// Host side of the three-wire write port.
// Every pin level is held for at least three clock cycles so the synchronisers never miss one.
module fmfl_host (
    // Clock.
    input wire logic mclk,
    // Serial pins.
    output logic ser_data,
    output logic ser_clk,
    output logic ser_le
);
    // Idle levels: serial clock and latch enable low.
    initial begin
        ser_data = 1'b0;
        ser_clk = 1'b0;
        ser_le = 1'b0;
    end

    // Shifts one word MSB first, then pulses the latch enable.
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            @(negedge mclk);
            ser_data = w[i];
            repeat (3) @(negedge mclk);
            ser_clk = 1'b1;
            repeat (3) @(negedge mclk);
            ser_clk = 1'b0;
        end
        repeat (3) @(negedge mclk);
        ser_le = 1'b1;
        repeat (3) @(negedge mclk);
        ser_le = 1'b0;
        ser_data = ~w[0]; // Stale data must not look like a held bit.
    endtask
endmodule // fmfl_host

`default_nettype wire

// File: dv/frac_modulus_fastlock_timer_test.sv
`timescale 1ns/10ps
`default_nettype none

module frac_modulus_fastlock_timer_test;
    import fmfl_pkg::*;
    logic mclk, rst_n, ce, pd, ser_data, ser_clk, ser_le, pin_o, pin_oe, active;
    fmfl_frac_t num, den;
    logic [4:0] pump;
    logic [2:0] shift;
    logic [9:0] hi, hd;
    logic [11:0] lo, ld;
    logic [13:0] t;
    logic [3:0] cpf;
    logic acc;
    int error_cnt = 0;
    int check_count = 0;
    integer seed = 41;

    ////////////////////////////////////////////////////////////////////////////
    // Clock, design and host model.
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    fmfl_timer i_dut (.MCLK(mclk), .RESETN(rst_n), .CE(ce), .SER_DATA(ser_data), .SER_CLK(ser_clk),
        .SER_LE(ser_le), .PD_COMPARE(pd), .FL_PIN_O(pin_o), .FL_PIN_OE(pin_oe), .FRAC_NUM(num),
        .FRAC_DEN(den), .FASTLOCK_ACTIVE(active), .FL_PUMP_MULT(pump), .CSR_SHIFT(shift));

    fmfl_host i_host (.mclk(mclk), .ser_data(ser_data), .ser_clk(ser_clk), .ser_le(ser_le));

    ////////////////////////////////////////////////////////////////////////////
    // Helpers and expectations.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Outputs settle five edges after the latch rise; four more cycles cover that.
    task automatic put(input logic [23:0] w);
        i_host.send(w);
        repeat (4) @(negedge mclk);
    endtask

    // Comparison events, each high and low for three cycles.
    task automatic pulses(input int n);
        repeat (n) begin
            pd = 1'b1;
            repeat (3) @(negedge mclk);
            pd = 1'b0;
            repeat (3) @(negedge mclk);
        end
        repeat (3) @(negedge mclk);
    endtask

    function automatic logic [21:0] exp_frac(input logic [9:0] h, input logic [11:0] l, input logic a);
        return a ? {h, l} : {10'h000, l};
    endfunction

    function automatic logic [2:0] exp_shift(input logic [1:0] c);
        return (c == 2'h3) ? 3'h4 : {1'b0, c};
    endfunction

    // A hang anywhere ends the run as a failure.
    initial begin
        repeat (90000) @(posedge mclk);
        error_cnt++;
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        pd = 1'b0;
        repeat (3) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        chk(num, 0);
        chk(den, 0);
        chk({pin_oe, pin_o, active, shift}, 0);
        chk(pump, 5'h01);
        $display("reset test done");

        // Boundary values 4095, 4096 and 4194303 in 22-bit mode only, among random ones of both widths.
        for (int k = 0; k < 8; k++) begin
            acc = k[0];
            hi = 10'($random(seed));
            lo = 12'($random(seed));
            hd = 10'($random(seed));
            ld = 12'($random(seed));
            if (k == 1) begin
                hi = 10'h000;
                lo = 12'hfff;
            end
            if (k == 3) begin
                hi = 10'h001;
                lo = 12'h000;
                hd = 10'h000;
            end
            if (k == 5) begin
                {hi, lo, hd, ld} = '1;
            end
            put({hi, 10'h000, 4'hb});
            put({10'h000, hd, 4'h5});
            put({7'h00, acc, ld, 4'h3});
            put({8'h00, lo, 4'h1});
            chk(num, exp_frac(hi, lo, acc));
            chk(den, exp_frac(hd, ld, acc));
        end
        $display("fraction test done");

        // Time-out codes 0 to 3, every cycle-slip code, pump codes 0 and 15.
        for (int c = 0; c < 4; c++) begin
            cpf = (c == 0) ? 4'h0 : (c == 3) ? 4'hf : 4'($random(seed));
            put({2'(c), cpf, 14'(c), 4'hd});
            chk(pin_oe, c != 0);
            chk(pin_o, c == 3);
            chk(active, c == 1);
            chk(shift, exp_shift(2'(c)));
            chk(pump, {1'b0, cpf} + 5'h01);
            if (c == 1) begin
                pulses(10);
                chk(active, 1);
            end
        end
        $display("control test done");

        // Timed fastlock at the smallest time-out and a random one above it.
        for (int n = 0; n < 2; n++) begin
            t = (n == 0) ? 14'h0004 : 14'h0005 + 14'($random(seed) & 7);
            put({2'h0, 4'h0, t, 4'hd});
            chk({active, pin_oe, pin_o}, 3'h7);
            pulses(2 * t - 1);
            chk(active, 1);
            // Events seen while the enable is low must not count towards the end.
            ce = 1'b0;
            pulses(2);
            ce = 1'b1;
            chk(active, 1);
            pulses(1);
            chk({active, pin_oe, pin_o}, 3'h2);
        end
        put({8'h00, 12'h005, 4'h1});
        chk(active, 1);
        $display("timed test done");
        summarize();
    end
endmodule // frac_modulus_fastlock_timer_test

`default_nettype wire
